// >>> pkg/cpr_pkg.sv
// package: register map, field layout and timing for pattern block
package cpr_pkg;
    // bus widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int PAT_W = 16;
    localparam int NUM_PAT = 7;
    // register indices, byte address is four times these
    localparam logic [15:0] IDX_PAT1 = 16'h4074;
    localparam logic [15:0] IDX_PAT2 = 16'h4076;
    localparam logic [15:0] IDX_PAT3 = 16'h4078;
    localparam logic [15:0] IDX_PAT4 = 16'h407a;
    localparam logic [15:0] IDX_PAT5 = 16'h407c;
    localparam logic [15:0] IDX_PAT6 = 16'h407e;
    localparam logic [15:0] IDX_PAT7 = 16'h4080;
    localparam logic [6:0][15:0] PAT_IDX = {IDX_PAT7, IDX_PAT6, IDX_PAT5,
        IDX_PAT4, IDX_PAT3, IDX_PAT2, IDX_PAT1};
    // block-local control and status indices
    localparam logic [15:0] IDX_CTRL = 16'h40a0;
    localparam logic [15:0] IDX_STAT = 16'h40a1;
    localparam logic [15:0] IDX_MASK = 16'h40a2;
    localparam logic [15:0] IDX_DRV = 16'h40a3;
    // pattern field layout, phase p: 0=u 1=v 2=w
    localparam int PAT_CPE_LSB = 12;
    localparam int PAT_HI_POL_LSB = 7;
    localparam int PAT_LO_POL_LSB = 6;
    localparam int PAT_HI_EN_LSB = 1;
    localparam int PAT_LO_EN_LSB = 0;
    localparam logic [15:0] PAT_WR_MASK = 16'h7fff;
    localparam logic [15:0] PAT_RESET = 16'h0000;
    // edge/comparator code: [1:0] comparator (0 none), [2] falling edge
    localparam int CPE_FALL_BIT = 2;
    // control register layout
    localparam int CTRL_CST_LSB = 0;
    localparam int CTRL_TSEL_LSB = 4;
    localparam int CTRL_SWUPD_BIT = 8;
    // transfer trigger select codes
    localparam logic [1:0] TSEL_SW = 2'h0;
    localparam logic [1:0] TSEL_OVF = 2'h1;
    localparam logic [1:0] TSEL_ADC_OR_OVF = 2'h2;
    localparam logic [1:0] TSEL_ADC_THEN_OVF = 2'h3;
    // interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_POS = 0;
    localparam int IRQ_XFER = 1;
    // dead time
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEAD_TIME_NS = 500;
    localparam int DT_CNT_W = 8;
    localparam logic [7:0] DEAD_CYC =
        8'((DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // dead-time sequencer states
    typedef enum logic [3:0] {
        DT_OFF = 4'b0001,
        DT_HIGH = 4'b0010,
        DT_GAP = 4'b0100,
        DT_LOW = 4'b1000
    } cpr_dt_e;
    // byte address of a printed index
    function automatic logic [ADDR_W-1:0] addr_of(input logic [15:0] idx);
        addr_of = {2'b00, idx, 2'b00};
    endfunction
endpackage

// >>> hdl/cpr_edge.sv
// selected-edge detector on the position detection inputs
module cpr_edge
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // position inputs and selection
    input wire logic [2:0] pos_i,
    input wire logic [2:0] cpe_i,
    input wire logic arm_i,
    // detection pulse
    output logic evt_o
);
    logic [2:0] prev_q; // last sample of all inputs
    logic evt_q; // registered pulse
    logic cur; // selected input now
    logic old; // selected input before
    logic hit; // edge match

    // pick comparator by low two bits, code 0 watches nothing
    always_comb
    begin
        cur = 1'b0;
        old = 1'b0;
        if (cpe_i[1:0] != 2'h0)
        begin
            cur = pos_i[cpe_i[1:0] - 2'h1];
            old = prev_q[cpe_i[1:0] - 2'h1];
        end
        if (cpe_i[cpr_pkg::CPE_FALL_BIT])
            hit = old & ~cur;
        else
            hit = cur & ~old;
    end

    // sample history, always running so arming sees no stale edge
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prev_q <= 3'h0;
        else
            prev_q <= pos_i;
    end

    // one-cycle event while armed
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            evt_q <= 1'b0;
        else
            evt_q <= arm_i & (cpe_i[1:0] != 2'h0) & hit;
    end

    assign evt_o = evt_q;
endmodule

// >>> hdl/cpr_deadtime.sv
// one phase of gate drive with complementary dead time
module cpr_deadtime
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // pattern bits for this phase
    input wire logic hi_en_i,
    input wire logic lo_en_i,
    input wire logic hi_pol_i,
    input wire logic lo_pol_i,
    // modulation input, high asks for high side
    input wire logic pwm_i,
    // gate pins
    output logic gate_hi_o,
    output logic gate_lo_o
);
    cpr_pkg::cpr_dt_e state_q; // sequencer state
    logic [7:0] cnt_q; // gap cycles left
    logic gate_hi_q; // high gate flop
    logic gate_lo_q; // low gate flop
    logic comp; // complementary mode
    logic hi_act; // high side on
    logic lo_act; // low side on

    assign comp = hi_en_i & lo_en_i;

    // in complementary mode never switch a side on directly from the other: always pass the gap
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= cpr_pkg::DT_OFF;
            cnt_q <= 8'h00;
        end
        else if (!comp)
        begin
            state_q <= cpr_pkg::DT_OFF;
            cnt_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                cpr_pkg::DT_OFF:
                begin
                    state_q <= cpr_pkg::DT_GAP;
                    cnt_q <= cpr_pkg::DEAD_CYC - 8'h01;
                end
                cpr_pkg::DT_HIGH:
                    if (!pwm_i)
                    begin
                        state_q <= cpr_pkg::DT_GAP;
                        cnt_q <= cpr_pkg::DEAD_CYC - 8'h01;
                    end
                cpr_pkg::DT_LOW:
                    if (pwm_i)
                    begin
                        state_q <= cpr_pkg::DT_GAP;
                        cnt_q <= cpr_pkg::DEAD_CYC - 8'h01;
                    end
                cpr_pkg::DT_GAP:
                    if (cnt_q == 8'h00)
                        state_q <= pwm_i ? cpr_pkg::DT_HIGH : cpr_pkg::DT_LOW;
                    else
                        cnt_q <= cnt_q - 8'h01;
                default:
                    state_q <= cpr_pkg::DT_OFF;
            endcase
        end
    end

    // active levels; single high side chops, single low side holds on
    always_comb
    begin
        if (comp)
        begin
            hi_act = (state_q == cpr_pkg::DT_HIGH);
            lo_act = (state_q == cpr_pkg::DT_LOW);
        end
        else
        begin
            hi_act = hi_en_i & pwm_i;
            lo_act = lo_en_i;
        end
    end

    // polarity applied last, so a disabled side rests at its inactive level
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            gate_hi_q <= 1'b0;
            gate_lo_q <= 1'b0;
        end
        else
        begin
            gate_hi_q <= hi_act ^ hi_pol_i;
            gate_lo_q <= lo_act ^ lo_pol_i;
        end
    end

    assign gate_hi_o = gate_hi_q;
    assign gate_lo_o = gate_lo_q;
endmodule

// >>> hdl/cpr_top.sv
// commutation pattern registers with apb slave, transfer and gate drive
//
// Register access over APB was chosen for this implementation.
module cpr_top
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [19:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // position detection and trigger sources
    input wire logic [2:0] pos_i,
    input wire logic comm_ovf_i,
    input wire logic adc_pos_i,
    // modulation per phase, index 0=u 1=v 2=w
    input wire logic [2:0] pwm_i,
    // gate drive and comparator enables
    output logic [2:0] gate_hi_o,
    output logic [2:0] gate_lo_o,
    output logic [2:0] cmp_en_o,
    // interrupt
    output logic irq_o
);
    // pattern storage, entry k holds pattern k+1
    logic [15:0] pat_q [cpr_pkg::NUM_PAT];
    logic [2:0] cst_q; // commutation state
    logic [1:0] tsel_q; // transfer trigger select
    logic xfer_pend_q; // software transfer pending
    logic [15:0] drv_q; // driver output pattern
    logic cmp_seen_q; // position event since last transfer
    logic [2:0] cmp_en_q; // comparator enables
    logic [1:0] stat_q; // sticky event bits
    logic [1:0] mask_q; // interrupt enables
    logic irq_q; // interrupt flop
    logic pready_q; // apb ready
    logic pslverr_q; // apb error
    logic [31:0] prdata_q; // apb read data
    // decode and helpers
    logic setup; // apb setup cycle
    logic wr; // write taking effect
    logic [6:0] hit_pat; // pattern hit per entry
    logic hit_ctrl; // control hit
    logic hit_stat; // status hit
    logic hit_mask; // mask hit
    logic hit_drv; // driver pattern hit
    logic hit_any; // mapped address
    logic [31:0] rdata_d; // read mux
    logic [15:0] wmask; // byte lanes as bit mask
    logic sw_trig; // software trigger
    logic xfer; // transfer this cycle
    logic pos_evt; // position detect pulse
    logic [2:0] cpe; // active edge/comparator field

    assign setup = psel_i & ~penable_i;
    assign wr = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
    assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign cpe = drv_q[cpr_pkg::PAT_CPE_LSB +: 3];

    // per-entry address match
    genvar k;
    generate
        for (k = 0; k < cpr_pkg::NUM_PAT; k++)
        begin : g_hit
            assign hit_pat[k] = (paddr_i == cpr_pkg::addr_of(cpr_pkg::PAT_IDX[k]));
        end
    endgenerate

    // address decode of block-local registers
    always_comb
    begin
        hit_ctrl = (paddr_i == cpr_pkg::addr_of(cpr_pkg::IDX_CTRL));
        hit_stat = (paddr_i == cpr_pkg::addr_of(cpr_pkg::IDX_STAT));
        hit_mask = (paddr_i == cpr_pkg::addr_of(cpr_pkg::IDX_MASK));
        hit_drv = (paddr_i == cpr_pkg::addr_of(cpr_pkg::IDX_DRV));
        hit_any = (|hit_pat) | hit_ctrl | hit_stat | hit_mask | hit_drv;
    end

    // read mux; reserved and upper bits read zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < cpr_pkg::NUM_PAT; i++)
        begin
            if (hit_pat[i])
                rdata_d = {16'h0000, pat_q[i]};
        end
        if (hit_ctrl)
        begin
            rdata_d[cpr_pkg::CTRL_CST_LSB +: 3] = cst_q;
            rdata_d[cpr_pkg::CTRL_TSEL_LSB +: 2] = tsel_q;
        end
        if (hit_stat)
            rdata_d[1:0] = stat_q;
        if (hit_mask)
            rdata_d[1:0] = mask_q;
        if (hit_drv)
            rdata_d[15:0] = drv_q;
    end

    // apb answer: data and error prepared in setup, one access cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            if (setup & ~pwrite_i)
                prdata_q <= rdata_d;
        end
    end

    // pattern registers, bit 15 reserved and never stored
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < cpr_pkg::NUM_PAT; i++)
                pat_q[i] <= cpr_pkg::PAT_RESET;
        end
        else
        begin
            for (int i = 0; i < cpr_pkg::NUM_PAT; i++)
            begin
                if (wr & hit_pat[i])
                    pat_q[i] <= ((pat_q[i] & ~wmask) | (pwdata_i[15:0] & wmask))
                        & cpr_pkg::PAT_WR_MASK;
            end
        end
    end

    // control: state and trigger select live in the low byte
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cst_q <= 3'h0;
            tsel_q <= cpr_pkg::TSEL_SW;
        end
        else if (wr & hit_ctrl & pstrb_i[0])
        begin
            cst_q <= pwdata_i[cpr_pkg::CTRL_CST_LSB +: 3];
            tsel_q <= pwdata_i[cpr_pkg::CTRL_TSEL_LSB +: 2];
        end
    end

    // software trigger: update bit, or any state write, in software mode
    assign sw_trig = wr & hit_ctrl & (tsel_q == cpr_pkg::TSEL_SW)
        & ((pstrb_i[1] & pwdata_i[cpr_pkg::CTRL_SWUPD_BIT]) | pstrb_i[0]);

    // delayed one cycle so the transfer sees the freshly written state
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            xfer_pend_q <= 1'b0;
        else
            xfer_pend_q <= sw_trig;
    end

    // trigger source per select code
    always_comb
    begin
        case (tsel_q)
            cpr_pkg::TSEL_SW: xfer = xfer_pend_q;
            cpr_pkg::TSEL_OVF: xfer = comm_ovf_i;
            cpr_pkg::TSEL_ADC_OR_OVF: xfer = adc_pos_i | comm_ovf_i;
            cpr_pkg::TSEL_ADC_THEN_OVF: xfer = cmp_seen_q ? comm_ovf_i : adc_pos_i;
            default: xfer = 1'b0;
        endcase
    end

    // tracks whether a comparator edge came since the last transfer
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cmp_seen_q <= 1'b0;
        else if (pos_evt)
            cmp_seen_q <= 1'b1; // set wins over transfer clear
        else if (xfer)
            cmp_seen_q <= 1'b0;
    end

    // driver output pattern, state 0 loads an all-off pattern
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            drv_q <= cpr_pkg::PAT_RESET;
        else if (xfer)
        begin
            if (cst_q == 3'h0)
                drv_q <= cpr_pkg::PAT_RESET;
            else
                drv_q <= pat_q[cst_q - 3'h1];
        end
    end

    // comparator enables follow the active field while state is nonzero
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cmp_en_q <= 3'h0;
        else if ((cst_q != 3'h0) && (cpe[1:0] != 2'h0))
            cmp_en_q <= 3'(3'h1 << (cpe[1:0] - 2'h1));
        else
            cmp_en_q <= 3'h0;
    end

    // edge detector, armed only while a pattern is selected
    cpr_edge u_edge
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pos_i(pos_i),
        .cpe_i(cpe),
        .arm_i(cst_q != 3'h0),
        .evt_o(pos_evt)
    );

    // sticky status, write one clears, a new event wins over the clear
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            stat_q <= 2'h0;
        else
        begin
            stat_q <= (stat_q & ~((wr & hit_stat & pstrb_i[0]) ? pwdata_i[1:0] : 2'h0))
                | {xfer, pos_evt};
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mask_q <= 2'h0;
        else if (wr & hit_mask & pstrb_i[0])
            mask_q <= pwdata_i[1:0];
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_q <= 1'b0;
        else
            irq_q <= |(stat_q & mask_q);
    end

    // one gate pair per phase from the transferred pattern
    genvar p;
    generate
        for (p = 0; p < 3; p++)
        begin : g_phase
            cpr_deadtime u_dt
            (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .hi_en_i(drv_q[cpr_pkg::PAT_HI_EN_LSB + 2*p]),
                .lo_en_i(drv_q[cpr_pkg::PAT_LO_EN_LSB + 2*p]),
                .hi_pol_i(drv_q[cpr_pkg::PAT_HI_POL_LSB + 2*p]),
                .lo_pol_i(drv_q[cpr_pkg::PAT_LO_POL_LSB + 2*p]),
                .pwm_i(pwm_i[p]),
                .gate_hi_o(gate_hi_o[p]),
                .gate_lo_o(gate_lo_o[p])
            );
        end
    endgenerate

    // outputs straight from flops
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;
    assign cmp_en_o = cmp_en_q;
    assign irq_o = irq_q;
endmodule

// >>> bench/cpr_top_properties.sv
// concurrent checks on the pattern block ports
module cpr_top_properties
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [19:0] paddr_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    // drive side
    input wire logic [2:0] gate_hi_o,
    input wire logic [2:0] gate_lo_o,
    input wire logic [2:0] cmp_en_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // decoded map; odd indices between patterns are holes
    function automatic logic mapped(input logic [19:0] a);
        mapped = a[19:4] == 16'h1028 && a[1:0] == 2'h0;
        for (int i = 0; i < 7; i++)
            if (a == {2'h0, cpr_pkg::PAT_IDX[i], 2'h0})
                mapped = 1'h1;
    endfunction
    // access phase always follows setup at once
    property p_rdy;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    // ready only answers a setup
    property p_rdy_cause;
        pready_o |-> $past(psel_i && !penable_i) && penable_i;
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("stray ready");
    // ready stands a single cycle
    property p_rdy_once;
        pready_o |=> !pready_o;
    endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
    // error exactly on unmapped accesses
    property p_err;
        pslverr_o == (pready_o && !mapped(paddr_i));
    endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    // read data only moves on a read setup
    property p_rdat;
        !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o);
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data moved");
    // at most one comparator enabled
    property p_cmp;
        $onehot0(cmp_en_o);
    endproperty
    a_cmp: assert property (p_cmp) else $error("several comparators");
    // all quiet straight after reset, no pattern selected
    property p_rst;
        $rose(nrst_i) |-> {gate_hi_o, gate_lo_o, cmp_en_o, irq_o, pready_o} == 11'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle");
    // interrupt drops only two edges after a register write
    property p_irq_fall;
        $fell(irq_o) |-> $past(pready_o && pwrite_i, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    c_err: cover property (pready_o && pslverr_o);
    c_irq: cover property ($rose(irq_o));
    c_cmp: cover property (cmp_en_o != 3'h0);
endmodule

bind cpr_top cpr_top_properties u_cpr_top_properties (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o),
    .gate_hi_o(gate_hi_o),
    .gate_lo_o(gate_lo_o),
    .cmp_en_o(cmp_en_o),
    .irq_o(irq_o)
);

// >>> bench/cpr_bridge_model.sv
// bridge model: switch states, phase node and shoot-through count
module cpr_bridge_model
(
    // clock
    input wire logic ref_clk_i,
    // gate pins, polarity pairs {hi,lo} per phase, watch enable
    input wire logic [2:0] gate_hi_i,
    input wire logic [2:0] gate_lo_i,
    input wire logic [5:0] pol_i,
    input wire logic en_i,
    // phase node and fault count
    output logic [2:0] phase_o,
    output int shoot_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hi_on; // switch conducting
    logic [2:0] lo_on;
    // undo the pin polarity to get the switch state
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            hi_on[p] = gate_hi_i[p] ^ pol_i[2*p+1];
            lo_on[p] = gate_lo_i[p] ^ pol_i[2*p];
        end
    end
    // floating node toggles so a stale level never passes
    always @(posedge ref_clk_i)
    begin
        for (int p = 0; p < 3; p++)
            phase_o[p] <= hi_on[p] ? 1'h1 : lo_on[p] ? 1'h0 : ~phase_o[p];
        if (en_i && |(hi_on & lo_on))
            shoot_o <= shoot_o + 1;
    end
    // known start level, so a floating node toggles instead of staying unknown
    initial
    begin
        shoot_o = 0;
        phase_o = 3'h0;
    end
endmodule

// >>> bench/cpr_top_tb.sv
// self-checking bench for the commutation pattern block
`define chk(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module cpr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // clock, reset, apb
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    // sources and drive
    logic [2:0] pos = 3'h0;
    logic ovf = 1'h0;
    logic adc = 1'h0;
    logic [2:0] pwm = 3'h0;
    logic [2:0] ghi;
    logic [2:0] glo;
    logic [2:0] cmp;
    logic irq;
    // model hooks
    logic [5:0] pol = 6'h0;
    logic en = 1'h0;
    logic [2:0] phase;
    int shoot;
    // bookkeeping
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rdat;
    logic rerr;
    always #25 clk = ~clk;
    cpr_top u_cpr_top (
        .ref_clk_i(clk), .nrst_i(nrst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .pos_i(pos), .comm_ovf_i(ovf), .adc_pos_i(adc), .pwm_i(pwm),
        .gate_hi_o(ghi), .gate_lo_o(glo), .cmp_en_o(cmp), .irq_o(irq)
    );
    cpr_bridge_model u_cpr_bridge_model (
        .ref_clk_i(clk), .gate_hi_i(ghi), .gate_lo_i(glo),
        .pol_i(pol), .en_i(en), .phase_o(phase), .shoot_o(shoot)
    );
    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer, request held until pready is sampled
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'h1, idx, d, 4'hf);
    endtask
    task automatic rd(input logic [15:0] idx);
        apb(1'h0, idx, 32'h0, 4'h0);
    endtask
    task automatic wctl(input logic [31:0] d);
        wr(cpr_pkg::IDX_CTRL, d);
    endtask
    // driver pattern readback against a worked-out value
    task automatic drv_is(input logic [15:0] e);
        rd(cpr_pkg::IDX_DRV);
        `chk("driver pattern", {16'h0, e}, rdat)
    endtask
    // one-cycle pulse on adc (a high) or overflow
    task automatic kick(input logic a);
        adc <= a;
        ovf <= ~a;
        @(posedge clk);
        adc <= 1'h0;
        ovf <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // reset values, reserved bit, byte lane, hole in the map
    task automatic t_regs();
        for (int i = 0; i < 7; i++)
        begin
            rd(cpr_pkg::PAT_IDX[i]);
            `chk("pattern reset", 32'h0, rdat)
        end
        wr(cpr_pkg::IDX_PAT1, 32'hffff_ffff);
        rd(cpr_pkg::IDX_PAT1);
        `chk("pattern bits", 32'h7fff, rdat)
        apb(1'h1, cpr_pkg::IDX_PAT1, 32'h0, 4'h1);
        rd(cpr_pkg::IDX_PAT1);
        `chk("low lane", 32'h7f00, rdat)
        rd(16'h4075);
        `chk("unmapped", 1'h1, rerr)
    endtask
    // every state picks its own pattern; single enables only
    task automatic t_drive();
        logic [15:0] pat;
        pwm <= 3'h7;
        for (int k = 1; k < 8; k++)
        begin
            pat = {4'h0, 6'(k * 11), 6'h06};
            pol <= pat[11:6];
            wr(cpr_pkg::PAT_IDX[k-1], {16'h0, pat});
            wctl(32'(k));
            repeat (4) @(posedge clk);
            drv_is(pat);
            `chk("gate high", {pat[11], pat[9], ~pat[7]}, ghi)
            `chk("gate low", {pat[10], ~pat[8], pat[6]}, glo)
            `chk("phase", 2'h1, phase[1:0])
        end
        wctl(32'h0);
        repeat (4) @(posedge clk);
        drv_is(16'h0);
        `chk("idle", 9'h0, {ghi, glo, cmp})
    endtask
    // both enables: complementary with a gap on the low-to-high change
    task automatic t_dead();
        pwm <= 3'h0;
        pol <= 6'h0;
        wr(cpr_pkg::IDX_PAT1, 32'h3);
        wctl(32'h1);
        repeat (20) @(posedge clk);
        en <= 1'h1;
        `chk("low on", 2'h1, {ghi[0], glo[0]})
        pwm <= 3'h1;
        repeat (3) @(posedge clk);
        `chk("gap start", 2'h0, {ghi[0], glo[0]})
        repeat (5) @(posedge clk);
        `chk("gap end", 2'h0, {ghi[0], glo[0]})
        repeat (8) @(posedge clk);
        `chk("high on", 2'h2, {ghi[0], glo[0]})
        en <= 1'h0;
        `chk("shoot through", 0, shoot)
    endtask
    // chosen edge on the chosen comparator raises the event
    task automatic t_pos();
        wr(cpr_pkg::IDX_PAT1, 32'h1000);
        wr(cpr_pkg::IDX_MASK, 32'h1);
        wctl(32'h1);
        repeat (3) @(posedge clk);
        `chk("comparator 1", 3'h1, cmp)
        `chk("masked", 1'h0, irq)
        pos <= 3'h1;
        repeat (4) @(posedge clk);
        `chk("rise event", 1'h1, irq)
        rd(cpr_pkg::IDX_STAT);
        `chk("status", 32'h3, rdat)
        wr(cpr_pkg::IDX_STAT, 32'h3);
        repeat (3) @(posedge clk);
        `chk("cleared", 1'h0, irq)
        pos <= 3'h3;
        wr(cpr_pkg::IDX_PAT1, 32'h6000);
        wctl(32'h1);
        repeat (3) @(posedge clk);
        `chk("comparator 2", 3'h2, cmp)
        `chk("no rise event", 1'h0, irq)
        pos <= 3'h1;
        repeat (4) @(posedge clk);
        `chk("fall event", 1'h1, irq)
        wr(cpr_pkg::IDX_MASK, 32'h0);
        repeat (3) @(posedge clk);
        `chk("mask off", 1'h0, irq)
        wr(cpr_pkg::IDX_STAT, 32'h3);
    endtask
    // every transfer trigger choice
    task automatic t_trig();
        pos <= 3'h0;
        wr(cpr_pkg::PAT_IDX[1], 32'h1022);
        wr(cpr_pkg::PAT_IDX[2], 32'h0024);
        wctl(32'h11);
        wctl(32'h12);
        drv_is(16'h6000);
        kick(1'h0);
        drv_is(16'h1022);
        wctl(32'h23);
        kick(1'h1);
        drv_is(16'h0024);
        wctl(32'h32);
        kick(1'h1);
        drv_is(16'h1022);
        pos <= 3'h1;
        wctl(32'h33);
        kick(1'h1);
        drv_is(16'h1022);
        kick(1'h0);
        drv_is(16'h0024);
        wctl(32'h2);
        wctl(32'h2);
        wr(cpr_pkg::PAT_IDX[1], 32'h0042);
        apb(1'h1, cpr_pkg::IDX_CTRL, 32'h100, 4'h2);
        drv_is(16'h0042);
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        t_regs();
        t_drive();
        t_dead();
        t_pos();
        t_trig();
        end_sim();
    end
    // hang guard; the run needs about 310 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
endmodule
